// ===== core/mpp_map.svh
// Purpose: Offsets, fields, reset values and timing for post-processing
// Assumes: APB word addressing, 40 MHz clock
// Notes: Times are kept in their own unit next to derived counts
`ifndef MPP_MAP_SVH
`define MPP_MAP_SVH
`define MPP_CTRL 8'h00
`define MPP_RECN 8'h04
`define MPP_MVAL 8'h08
`define MPP_REDN 8'h0C
`define MPP_CMD 8'h10
`define MPP_STAT 8'h14
`define MPP_OFFS 8'h18
`define MPP_F_MODE 1:0
`define MPP_F_MLEN 7:4
`define MPP_B_MEN 8
`define MPP_B_RDIG 9
`define MPP_B_RANA 10
`define MPP_B_LOCKEN 11
`define MPP_B_CMASTER 0
`define MPP_B_CZERO 1
`define MPP_B_CUNLOCK 2
`define MPP_B_STO 0
`define MPP_B_SRANGE 1
`define MPP_B_SBUSY 2
`define MPP_B_SLOCK 3
`define MPP_B_SMACT 4
`define MPP_MODE_OFF 2'h0
`define MPP_MODE_REC 2'h1
`define MPP_MODE_MED 2'h2
`define MPP_CTRL_RST 32'h00000892
`define MPP_RECN_RST 15'h0002
`define MPP_RECN_MIN 15'h0002
`define MPP_REDN_RST 22'h000001
`define MPP_REDN_MAX 22'h2DC6C0
`define MPP_CLK_HZ 40000000
`define MPP_TICK_MS 1
`define MPP_TICK_CYC (`MPP_CLK_HZ / 1000 * `MPP_TICK_MS)
`define MPP_TMO_MS 2000
`define MPP_FLASH_MS 2000
`define MPP_FLASH_HZ 8
`define MPP_HALF_MS (1000 / (2 * `MPP_FLASH_HZ))
`define MPP_LOCK_MIN 5
`define MPP_LOCK_MS (`MPP_LOCK_MIN * 60 * 1000)
`define MPP_FRAC 16
`endif

// ===== core/mpp_pkg.sv
// Purpose: Types shared by the post-processing block
// Assumes: Nothing beyond the map header
// Notes: Encodings left to the tools
package mpp_pkg;
   typedef enum logic [1:0] {AVG_IDLE, AVG_MED, AVG_DIV, AVG_DONE} mpp_avg_t;
   typedef enum logic {MS_IDLE, MS_WAIT} mpp_ms_t;
endpackage

// ===== core/mpp_top.sv
// Purpose: Averaging, mastering and output reduction of a sample stream
// Assumes: One sample at most every 60 cycles; APB slave, no wait states
// Notes: Samples arriving while the divider runs are dropped
// Functional notes
// [RULE1] Recursive output: (x+(N-1)*prev)/N
// [RULE2] Recursive N accepted from 2 to 32767
// [RULE3] Median of last 3/5/7/9 samples
// [RULE4] Median window of one never accepted
// [RULE5] Master value accepted 0 to twice range
// [RULE6] Zeroing equals mastering with value zero
// [RULE7] Wait 2 s for sample, else timeout
// [RULE8] Offset makes captured sample read master value
// [RULE9] Inactive setting removes mastering offset
// [RULE10] Invalid captured sample gives range error
// [RULE11] Offset applies to digital and analog
// [RULE12] Requester masters only with target present; no target-present input here, any request not refused starts mastering
// [RULE13] Select key locks after 5 minutes
// [RULE14] Requester spaces master requests by 1 s; no spacing timer here, a request is taken whenever mastering is idle
// [RULE15] Red state refuses, flashes 8 Hz 2 s
// [RULE16] Key or function pulse both request
// [RULE17] Output every nth value, n 1..3000000
// [RULE18] Reduction only on selected interfaces
// [RULE19] Measuring rate unchanged by reduction
// [RULE20] Averaging precedes every output
// [RULE21] Default averaging median of nine
// [RULE22] Inactive averaging passes samples through
// [RULE23] Order: average, offset, reduce
// [RULE24] Recursive state keeps fraction bits
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "mpp_map.svh"
module mpp_top #(
   parameter int W = 16,
   parameter logic [W:0] RANGE = 17'h0FFFF,
   parameter int TICK_CYC = `MPP_TICK_CYC,
   parameter int TMO_MS = `MPP_TMO_MS,
   parameter int FLASH_MS = `MPP_FLASH_MS,
   parameter int LOCK_MS = `MPP_LOCK_MS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_valid,
   input wire logic [W-1:0] measurement_sample,
   input wire logic sample_ok,
   input wire logic key_press,
   input wire logic func_pulse,
   input wire logic state_red,
   output logic led_flash,
   output logic dig_valid,
   output logic signed [W+1:0] dig_data,
   output logic ana_valid,
   output logic signed [W+1:0] ana_data
);
   localparam int F = `MPP_FRAC;
   localparam int NW = W + F + 16;
   logic [31:0] ctrl, next_ctrl;
   logic [14:0] rec_n, next_rec_n;
   logic [W:0] mval, next_mval;
   logic [21:0] red_n, next_red_n;
   logic master_timeout_error, next_to, master_range_error, next_re;
   logic [31:0] rd;
   logic wr, ack, req_m, req_z, unlock;
   logic key_locked;
   logic signed [W+1:0] offset;
   logic master_active;
   mpp_pkg::mpp_ms_t ms_st;
   assign ack = psel && penable && pready;
   assign wr = ack && pwrite;
   assign req_m = wr && paddr == `MPP_CMD && pwdata[`MPP_B_CMASTER];
   assign req_z = wr && paddr == `MPP_CMD && pwdata[`MPP_B_CZERO];
   assign unlock = wr && paddr == `MPP_CMD && pwdata[`MPP_B_CUNLOCK];
   // Register file; illegal values leave the old setting in place
   always_comb
   begin
      next_ctrl = ctrl;
      next_rec_n = rec_n;
      next_mval = mval;
      next_red_n = red_n;
      if (wr && paddr == `MPP_CTRL)
      begin
         next_ctrl = {20'h00000, pwdata[11:8], ctrl[7:0]};
         // [RULE22] Mode set
         if (pwdata[`MPP_F_MODE] != 2'h3)
            next_ctrl[`MPP_F_MODE] = pwdata[`MPP_F_MODE];
         // [RULE4] Odd length 3..9
         if (pwdata[4] && pwdata[`MPP_F_MLEN] >= 4'h3
             && pwdata[`MPP_F_MLEN] <= 4'h9)
            next_ctrl[`MPP_F_MLEN] = pwdata[`MPP_F_MLEN];
      end
      // [RULE2] N range check
      if (wr && paddr == `MPP_RECN && pwdata[31:15] == 17'h00000
          && pwdata[14:0] >= `MPP_RECN_MIN)
         next_rec_n = pwdata[14:0];
      if (wr && paddr == `MPP_MVAL && pwdata[31:W+1] == '0)
         next_mval = pwdata[W:0];
      // [RULE17] n from 1 to 3000000
      if (wr && paddr == `MPP_REDN && pwdata[31:22] == 10'h000
          && pwdata[21:0] != 22'h000000 && pwdata[21:0] <= `MPP_REDN_MAX)
         next_red_n = pwdata[21:0];
      rd = 32'h00000000;
      case (paddr)
         `MPP_CTRL: rd = ctrl;
         `MPP_RECN: rd = {17'h00000, rec_n};
         `MPP_MVAL: rd = {{(31-W){1'b0}}, mval};
         `MPP_REDN: rd = {10'h000, red_n};
         `MPP_STAT: rd = {27'h0000000, master_active, key_locked,
                          ms_st == mpp_pkg::MS_WAIT, master_range_error,
                          master_timeout_error};
         `MPP_OFFS: rd = {{(30-W){offset[W+1]}}, offset};
         default: rd = 32'h00000000;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // [RULE21] Median nine default
         ctrl <= `MPP_CTRL_RST;
         rec_n <= `MPP_RECN_RST;
         mval <= '0;
         red_n <= `MPP_REDN_RST;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         ctrl <= next_ctrl;
         rec_n <= next_rec_n;
         mval <= next_mval;
         red_n <= next_red_n;
         pready <= psel && !penable;
         pslverr <= psel && !penable
            && (paddr > `MPP_OFFS || paddr[1:0] != 2'h0);
         prdata <= rd;
      end
   end
   // Averaging stage
   mpp_pkg::mpp_avg_t av_st, next_av_st;
   logic [W-1:0] win [9], next_win [9];
   logic [W+F-1:0] acc, next_acc;
   logic [NW-1:0] num, next_num;
   logic [15:0] rem, next_rem;
   logic [5:0] cnt, next_cnt;
   logic av_ok, next_av_ok, av_v, next_av_v;
   logic [W-1:0] av_d, next_av_d, med;
   logic [3:0] rank, len;
   logic [16:0] trial;
   assign len = ctrl[`MPP_F_MLEN];
   // [RULE3] Rank count sort
   always_comb
   begin
      med = win[0];
      for (int i = 0; i < 9; i++)
      begin
         rank = 4'h0;
         for (int j = 0; j < 9; j++)
            if (j < len && j != i && (win[j] < win[i]
                || (win[j] == win[i] && j < i)))
               rank = rank + 4'h1;
         if (i < len && rank == (len >> 1))
            med = win[i];
      end
   end
   always_comb
   begin
      next_av_st = av_st;
      next_win = win;
      next_acc = acc;
      next_num = num;
      next_rem = rem;
      next_cnt = cnt;
      next_av_ok = av_ok;
      next_av_v = 1'b0;
      next_av_d = av_d;
      trial = {rem, num[NW-1]};
      case (av_st)
         mpp_pkg::AVG_IDLE:
            if (sample_valid)
            begin
               next_win[0] = measurement_sample;
               for (int k = 1; k < 9; k++)
                  next_win[k] = win[k-1];
               next_av_ok = sample_ok;
               next_av_st = mpp_pkg::AVG_MED;
               // [RULE22] Pass through
               if (ctrl[`MPP_F_MODE] == `MPP_MODE_OFF)
               begin
                  next_av_d = measurement_sample;
                  next_av_v = 1'b1;
                  next_av_st = mpp_pkg::AVG_IDLE;
               end
               // [RULE1] Weighted numerator
               else if (ctrl[`MPP_F_MODE] == `MPP_MODE_REC)
               begin
                  next_num = NW'({measurement_sample, F'(0)})
                     + NW'(rec_n - 15'h0001) * NW'(acc);
                  next_rem = 16'h0000;
                  next_cnt = 6'(NW);
                  next_av_st = mpp_pkg::AVG_DIV;
               end
            end
         mpp_pkg::AVG_MED:
         begin
            next_av_d = med;
            next_av_v = 1'b1;
            next_av_st = mpp_pkg::AVG_IDLE;
         end
         mpp_pkg::AVG_DIV:
         begin
            // [RULE24] Restoring division, truncating
            next_num = {num[NW-2:0], 1'b0};
            next_rem = trial[15:0];
            if (trial >= {2'b00, rec_n})
            begin
               next_rem = 16'(trial - {2'b00, rec_n});
               next_num[0] = 1'b1;
            end
            next_cnt = cnt - 6'h01;
            if (cnt == 6'h01)
               next_av_st = mpp_pkg::AVG_DONE;
         end
         mpp_pkg::AVG_DONE:
         begin
            next_acc = num[W+F-1:0];
            next_av_d = num[W+F-1:F];
            next_av_v = 1'b1;
            next_av_st = mpp_pkg::AVG_IDLE;
         end
         default: next_av_st = mpp_pkg::AVG_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         av_st <= mpp_pkg::AVG_IDLE;
         for (int k = 0; k < 9; k++)
            win[k] <= '0;
         acc <= '0;
         num <= '0;
         rem <= 16'h0000;
         cnt <= 6'h00;
         av_ok <= 1'b0;
         av_v <= 1'b0;
         av_d <= '0;
      end
      else
      begin
         av_st <= next_av_st;
         win <= next_win;
         acc <= next_acc;
         num <= next_num;
         rem <= next_rem;
         cnt <= next_cnt;
         av_ok <= next_av_ok;
         av_v <= next_av_v;
         av_d <= next_av_d;
      end
   end
   // Mastering, key lock and timers on a 1 ms enable
   mpp_pkg::mpp_ms_t next_ms_st;
   logic [31:0] div, next_div, ms, next_ms, lk, next_lk, fl, next_fl;
   logic tick, next_lock, next_flash, flashing, next_flashing, zero_req;
   logic next_zero_req, next_mact, req, key_req;
   logic [W:0] tgt;
   logic signed [W+1:0] next_offset;
   // [RULE13] Locked key ignored
   assign key_req = key_press && !key_locked;
   // [RULE16] Either source
   assign req = req_m || req_z || key_req || func_pulse;
   assign tick = div == 32'(TICK_CYC - 1);
   assign tgt = zero_req ? '0 : mval;
   always_comb
   begin
      next_div = tick ? 32'h00000000 : div + 32'h00000001;
      next_ms_st = ms_st;
      next_ms = ms;
      next_zero_req = zero_req;
      next_offset = offset;
      next_mact = master_active;
      next_to = master_timeout_error;
      next_re = master_range_error;
      next_flashing = flashing;
      next_fl = fl;
      next_flash = led_flash;
      next_lk = lk;
      next_lock = key_locked;
      if (wr && paddr == `MPP_STAT)
      begin
         next_to = master_timeout_error && !pwdata[`MPP_B_STO];
         next_re = master_range_error && !pwdata[`MPP_B_SRANGE];
      end
      // [RULE13] Five minute lock
      if (unlock || !ctrl[`MPP_B_LOCKEN])
      begin
         next_lk = 32'h00000000;
         next_lock = 1'b0;
      end
      else if (tick && !key_locked)
      begin
         next_lk = lk + 32'h00000001;
         next_lock = lk == 32'(LOCK_MS - 1);
      end
      // [RULE15] 8 Hz for 2 s
      if (flashing && tick)
      begin
         next_fl = fl + 32'h00000001;
         if ((fl + 32'h00000001) % 32'(`MPP_HALF_MS) == 32'h00000000)
            next_flash = !led_flash;
         if (fl == 32'(FLASH_MS - 1))
         begin
            next_flashing = 1'b0;
            next_flash = 1'b0;
         end
      end
      // [RULE9] Inactive clears offset
      if (!ctrl[`MPP_B_MEN])
      begin
         next_offset = '0;
         next_mact = 1'b0;
         next_ms_st = mpp_pkg::MS_IDLE;
      end
      else
         case (ms_st)
            mpp_pkg::MS_IDLE:
               if (req && state_red)
               begin
                  // [RULE15] Refused while red
                  next_flashing = 1'b1;
                  next_fl = 32'h00000000;
                  next_flash = 1'b1;
               end
               // [RULE5] Master up to twice range
               else if (req && !req_z && {1'b0, mval} > {RANGE, 1'b0})
                  next_re = 1'b1;
               else if (req)
               begin
                  // [RULE6] Zero target
                  next_zero_req = req_z;
                  next_ms = 32'h00000000;
                  next_ms_st = mpp_pkg::MS_WAIT;
               end
            mpp_pkg::MS_WAIT:
               if (av_v)
               begin
                  next_ms_st = mpp_pkg::MS_IDLE;
                  // [RULE10] Invalid capture
                  if (!av_ok)
                     next_re = 1'b1;
                  else
                  begin
                     // [RULE8] Parallel shift
                     next_offset = (W+2)'({1'b0, tgt}) - (W+2)'({2'b00, av_d});
                     next_mact = 1'b1;
                  end
               end
               else if (tick)
               begin
                  next_ms = ms + 32'h00000001;
                  // [RULE7] Two second timeout
                  if (ms == 32'(TMO_MS - 1))
                  begin
                     next_to = 1'b1;
                     next_ms_st = mpp_pkg::MS_IDLE;
                  end
               end
            default: next_ms_st = mpp_pkg::MS_IDLE;
         endcase
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div <= 32'h00000000;
         ms_st <= mpp_pkg::MS_IDLE;
         ms <= 32'h00000000;
         zero_req <= 1'b0;
         offset <= '0;
         master_active <= 1'b0;
         master_timeout_error <= 1'b0;
         master_range_error <= 1'b0;
         flashing <= 1'b0;
         fl <= 32'h00000000;
         led_flash <= 1'b0;
         lk <= 32'h00000000;
         key_locked <= 1'b0;
      end
      else
      begin
         div <= next_div;
         ms_st <= next_ms_st;
         ms <= next_ms;
         zero_req <= next_zero_req;
         offset <= next_offset;
         master_active <= next_mact;
         master_timeout_error <= next_to;
         master_range_error <= next_re;
         flashing <= next_flashing;
         fl <= next_fl;
         led_flash <= next_flash;
         lk <= next_lk;
         key_locked <= next_lock;
      end
   end
   // Output stage: offset then reduction
   logic [21:0] rc, next_rc;
   logic hit, next_dv, next_anv;
   logic signed [W+1:0] val;
   // [RULE20] Averaged value feeds outputs
   // [RULE11] Both outputs offset
   // Next offset, so the captured sample already reads the master value
   assign val = (W+2)'({2'b00, av_d}) + next_offset;
   // [RULE19] Counting only at output
   assign hit = rc == red_n - 22'h000001;
   always_comb
   begin
      next_rc = rc;
      if (av_v)
         next_rc = hit ? 22'h000000 : rc + 22'h000001;
      // [RULE18] Selected interfaces only
      next_dv = av_v && (!ctrl[`MPP_B_RDIG] || hit);
      next_anv = av_v && (!ctrl[`MPP_B_RANA] || hit);
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rc <= 22'h000000;
         dig_valid <= 1'b0;
         ana_valid <= 1'b0;
         dig_data <= '0;
         ana_data <= '0;
      end
      else
      begin
         rc <= next_rc;
         // [RULE23] Average, offset, reduce
         dig_valid <= next_dv;
         ana_valid <= next_anv;
         if (next_dv)
            dig_data <= val;
         if (next_anv)
            ana_data <= val;
      end
   end
endmodule // mpp_top

// ===== verification/measurement_postprocess_bench.sv
// Purpose: Directed checks of averaging, mastering and reduction
// Assumes: Millisecond tick scaled to 10 cycles
// Notes: Request spacing dominates run time
`timescale 1ns/1ps
`include "mpp_map.svh"
module measurement_postprocess_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, led_flash, dig_valid, ana_valid;
   logic sample_valid, sample_ok, key_press, func_pulse, state_red;
   logic [15:0] measurement_sample;
   logic signed [17:0] dig_data, ana_data;
   logic [17:0] last_dig, last_ana;
   logic [15:0] med[7] = '{16'h0, 16'h1, 16'h2, 16'h4, 16'h5, 16'h1, 16'h3};
   int num_errors = 0;
   int n_tests = 0;
   int n_dig = 0;
   int n_ana = 0;
   int d0, a0;
   always #12.5 clk = ~clk;
   mpp_top #(.TICK_CYC(10), .TMO_MS(20), .LOCK_MS(100)) dut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
      .measurement_sample(measurement_sample), .sample_ok(sample_ok),
      .key_press(key_press), .func_pulse(func_pulse),
      .state_red(state_red), .led_flash(led_flash),
      .dig_valid(dig_valid), .dig_data(dig_data),
      .ana_valid(ana_valid), .ana_data(ana_data));
   mpp_host host (.clk(clk), .rst_n(rst_n), .sample_valid(sample_valid),
      .measurement_sample(measurement_sample), .sample_ok(sample_ok),
      .key_press(key_press), .func_pulse(func_pulse),
      .state_red(state_red));
   always @(posedge clk)
   begin
      if (dig_valid === 1'b1) {last_dig, n_dig} <= {dig_data, n_dig + 1};
      if (ana_valid === 1'b1) {last_ana, n_ana} <= {ana_data, n_ana + 1};
   end
   task conclude();
      if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   task reset();
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   // Request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, '0);
      chk(rd, exp);
   endtask
   task so(input logic [15:0] v, input logic [17:0] exp);
      host.send(v, 1'b1);
      chk(last_ana, exp);
      chk(last_dig, exp);
   endtask
   initial
   begin
      repeat (95000) @(posedge clk);
      num_errors++;
      conclude();
   end
   initial
   begin
      reset();
      rchk(`MPP_CTRL, `MPP_CTRL_RST);
      rchk(`MPP_RECN, 32'h2);
      rchk(`MPP_REDN, 32'h1);
      apb(1'b0, 8'h1C, '0);
      chk({31'h0, err}, 32'h1);
      so(16'h0040, 18'h0);
      apb(1'b1, `MPP_CTRL, 32'h052);
      foreach (med[i]) host.send(med[i], 1'b1);
      chk(last_ana, 18'h3);
      so(16'h5, 18'h4);
      apb(1'b1, `MPP_CTRL, 32'h012);
      rchk(`MPP_CTRL, 32'h052);
      apb(1'b1, `MPP_CTRL, 32'h0);
      so(16'h0064, 18'h64);
      apb(1'b1, `MPP_REDN, 32'h3);
      apb(1'b1, `MPP_CTRL, 32'h200);
      {d0, a0} = {n_dig, n_ana};
      repeat (6) host.send(16'h7, 1'b1);
      chk(n_dig - d0, 32'h2);
      chk(n_ana - a0, 32'h6);
      apb(1'b1, `MPP_REDN, 32'h2DC6C0);
      rchk(`MPP_REDN, 32'h2DC6C0);
      apb(1'b1, `MPP_RECN, 32'h1);
      rchk(`MPP_RECN, 32'h2);
      apb(1'b1, `MPP_RECN, 32'h7FFF);
      rchk(`MPP_RECN, 32'h7FFF);
      reset();
      apb(1'b1, `MPP_CTRL, 32'h801);
      so(16'h0064, 18'h32);
      so(16'h0064, 18'h4B);
      apb(1'b1, `MPP_CTRL, 32'h900);
      apb(1'b1, `MPP_MVAL, 32'h1F4);
      host.key();
      so(16'h00C8, 18'h1F4);
      so(16'h00D2, 18'h1FE);
      apb(1'b0, `MPP_STAT, '0);
      chk(rd & 32'h17, 32'h10);
      rchk(`MPP_OFFS, 32'h12C);
      host.space();
      apb(1'b1, `MPP_CMD, 32'h2);
      so(16'h012C, 18'h0);
      apb(1'b1, `MPP_MVAL, 32'h1FFFE);
      host.func();
      so(16'h0028, 18'h1FFFE);
      host.space();
      apb(1'b1, `MPP_CMD, 32'h1);
      repeat (300) @(posedge clk);
      apb(1'b0, `MPP_STAT, '0);
      chk(rd & 32'h1, 32'h1);
      apb(1'b1, `MPP_STAT, 32'h1);
      host.space();
      apb(1'b1, `MPP_CMD, 32'h1);
      host.send(16'h0028, 1'b0);
      apb(1'b0, `MPP_STAT, '0);
      chk(rd & 32'h3, 32'h2);
      so(16'h0028, 18'h1FFFE);
      // Master value just above twice the range
      apb(1'b1, `MPP_STAT, 32'h2);
      apb(1'b1, `MPP_MVAL, 32'h1FFFF);
      host.func();
      apb(1'b0, `MPP_STAT, '0);
      chk(rd & 32'h6, 32'h2);
      apb(1'b1, `MPP_MVAL, 32'h0);
      host.red(1'b1);
      host.func();
      repeat (4) @(posedge clk);
      chk({31'h0, led_flash}, 32'h1);
      so(16'h0028, 18'h1FFFE);
      // First 8 Hz toggle lands 62 ticks after the refusal
      repeat (600) @(posedge clk);
      chk({31'h0, led_flash}, 32'h0);
      host.red(1'b0);
      apb(1'b1, `MPP_CTRL, 32'h800);
      so(16'h007B, 18'h7B);
      apb(1'b0, `MPP_STAT, '0);
      chk(rd & 32'h8, 32'h8);
      apb(1'b1, `MPP_CTRL, 32'h900);
      host.key();
      repeat (3) @(posedge clk);
      apb(1'b0, `MPP_STAT, '0);
      chk(rd & 32'h4, 32'h0);
      apb(1'b1, `MPP_CMD, 32'h4);
      apb(1'b0, `MPP_STAT, '0);
      chk(rd & 32'h8, 32'h0);
      conclude();
   end
endmodule // measurement_postprocess_bench

// ===== verification/mpp_chk.sv
// Purpose: Port assertions for the post-processing block
// Assumes: Samples spaced by at least 60 cycles
// Notes: Control fields tracked from APB writes
`timescale 1ns/1ps
`include "mpp_map.svh"
module mpp_chk #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic sample_valid,
   input wire logic [W-1:0] measurement_sample,
   input wire logic func_pulse,
   input wire logic state_red,
   input wire logic led_flash,
   input wire logic dig_valid,
   input wire logic signed [W+1:0] dig_data,
   input wire logic ana_valid,
   input wire logic signed [W+1:0] ana_data
);
   logic [31:0] ctrl;
   logic [31:0] next_ctrl;
   logic touched;
   logic next_touched;
   logic [1:0] mode;
   logic men;
   logic rdig;
   logic rana;
   always_comb
   begin
      next_ctrl = ctrl;
      next_touched = touched;
      if (psel && penable && pready && pwrite && paddr == `MPP_CTRL)
      begin
         next_ctrl = pwdata;
         next_touched = 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl <= `MPP_CTRL_RST;
         touched <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         touched <= next_touched;
      end
   end
   assign mode = ctrl[`MPP_F_MODE];
   assign men = ctrl[`MPP_B_MEN];
   assign rdig = ctrl[`MPP_B_RDIG];
   assign rana = ctrl[`MPP_B_RANA];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_off_pass: assert property (sample_valid
      && mode == `MPP_MODE_OFF && !men && !rana |-> ##2 ana_valid
      && ana_data == {2'b00, $past(measurement_sample, 2)})
      else $error("unaveraged sample not passed through");
   a_med_latency: assert property (sample_valid && touched
      && mode == `MPP_MODE_MED && !rana |-> ##3 ana_valid)
      else $error("median output missing");
   a_default_median: assert property (sample_valid && !touched
      |-> ##3 ana_valid)
      else $error("default median output missing");
   a_rec_latency: assert property (sample_valid
      && mode == `MPP_MODE_REC && !rana |-> ##51 ana_valid)
      else $error("recursive output missing");
   a_dig_unreduced: assert property (ana_valid && !rdig
      |-> dig_valid)
      else $error("unreduced digital value dropped");
   a_paths_equal: assert property (dig_valid && ana_valid
      |-> dig_data == ana_data)
      else $error("digital and analog values differ");
   a_red_flash: assert property (func_pulse && state_red && men
      |-> ##[1:4] led_flash)
      else $error("no flash on refused request");
   a_from_sample: assert property (ana_valid
      |-> $past(sample_valid, 2) || $past(sample_valid, 3)
      || $past(sample_valid, 51))
      else $error("output without a sample");
   c_flash: cover property (led_flash);
   c_mastered: cover property (dig_valid && men);
   c_reduced: cover property (ana_valid && !dig_valid);
endmodule // mpp_chk
bind mpp_top mpp_chk #(.W(W)) u_chk (.clk(clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .sample_valid(sample_valid),
   .measurement_sample(measurement_sample), .func_pulse(func_pulse),
   .state_red(state_red), .led_flash(led_flash), .dig_valid(dig_valid),
   .dig_data(dig_data), .ana_valid(ana_valid), .ana_data(ana_data));

// ===== verification/mpp_host.sv
// Purpose: Sample source, select key and function input model
// Assumes: Driven from bench tasks on rising edges
// Notes: Released sample lines show inverted data
`timescale 1ns/1ps
module mpp_host #(
   parameter int W = 16,
   parameter int GAP = 10000
) (
   input wire logic clk,
   input wire logic rst_n,
   output logic sample_valid,
   output logic [W-1:0] measurement_sample,
   output logic sample_ok,
   output logic key_press,
   output logic func_pulse,
   output logic state_red
);
   int since = GAP;
   logic mark = 1'b0;
   initial
   begin
      {sample_valid, sample_ok, key_press, func_pulse, state_red} = '0;
      measurement_sample = '0;
   end
   always @(posedge clk or negedge rst_n)
      if (!rst_n) since <= GAP;
      else if (mark) since <= 0;
      else if (since < GAP) since <= since + 1;
   task space();
      while (since < GAP) @(posedge clk);
      @(posedge clk) mark <= 1'b1;
      @(posedge clk) mark <= 1'b0;
   endtask
   task send(input logic [W-1:0] v, input logic ok);
      @(posedge clk);
      {sample_valid, sample_ok, measurement_sample} <= {1'b1, ok, v};
      @(posedge clk);
      {sample_valid, sample_ok, measurement_sample} <= {1'b0, !ok, ~v};
      repeat (70) @(posedge clk);
   endtask
   task key();
      space();
      key_press <= 1'b1;
      @(posedge clk) key_press <= 1'b0;
   endtask
   task func();
      space();
      func_pulse <= 1'b1;
      @(posedge clk) func_pulse <= 1'b0;
   endtask
   task red(input logic b);
      @(posedge clk) state_red <= b;
   endtask
endmodule // mpp_host
